// file: fpil_pkg.sv
// fpil_pkg: constants, types and register map for the fire panel indicator logic.
// assumes a single 250 MHz clock and an AHB-Lite master with whole-word single transfers.
package fpil_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_MHZ = 250;
	localparam int TICK_MS = 50;                     // timebase tick, half the rapid period
	localparam int TICK_CYCLES = TICK_MS * CLK_MHZ * 1000;
	localparam int RAPID_PERIOD_MS = 100;            // ten flashes per second
	localparam int NORM_PERIOD_MS = 500;             // half a second
	localparam int SLOW_PERIOD_MS = 2000;            // two seconds
	localparam int RAPID_HALF_TICKS = RAPID_PERIOD_MS / (2 * TICK_MS);
	localparam int NORM_HALF_TICKS = NORM_PERIOD_MS / (2 * TICK_MS);
	localparam int SLOW_HALF_TICKS = SLOW_PERIOD_MS / (2 * TICK_MS);
	localparam int RESTART_HOURS = 8;
	localparam int RESTART_TICKS = RESTART_HOURS * 3600 * 1000 / TICK_MS;
	localparam int FAILHOLD_MIN = 1;
	localparam int FAILHOLD_TICKS = FAILHOLD_MIN * 60 * 1000 / TICK_MS;

	// ------------------------------------------------------------
	// register map (byte addresses) and fields
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_FAULTCNT = 8'h08;
	localparam logic [7:0] ADDR_ZONEFLT = 8'h0c;
	localparam int CTRL_MAXZONE_LSB = 0;             // 8-bit isolate maximum zone
	localparam int CTRL_BELLNET_BIT = 8;             // networked bell isolate feature enable
	localparam int CTRL_WARNNET_BIT = 9;             // networked warning isolation enable, not read by any logic
	localparam int CTRL_MUTE_LSB = 16;               // 4-bit sounder mute per fault source
	localparam logic [31:0] CTRL_RESET = 32'h0000_00ff;
	localparam int MUTE_ZONE = 0;
	localparam int MUTE_SYS = 1;
	localparam int MUTE_CHG = 2;
	localparam int MUTE_BAT = 3;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {LAMP_OFF, LAMP_ON, LAMP_SLOW, LAMP_NORM, LAMP_RAPID} fpil_lamp_t;
	typedef enum logic [1:0] {SND_QUIET, SND_SOUNDING, SND_SILENCED} fpil_snd_t;

	typedef struct packed {
		logic mainsPresent;
		logic chargerFault;
		logic batteryLow;
		logic batteryDisconnected;
		logic batteryTestRunning;
		logic batteryTestDone;        // one-cycle pulse at test end
		logic batteryTestPass;        // valid with batteryTestDone
		logic systemFault;
		logic dbDownload;
		logic bellLocalIso;
		logic bellNetIso;
		logic warnLocalIso;
		logic warnRemoteSilence;
		logic warnLocalExtSilence;
		logic unackListAlarm;
		logic unackMasterUnlisted;
		logic pointIsolated;
		logic atBaseDisplay;
	} fpil_cond_t;

	typedef struct packed {
		logic clearKey;
		logic ackKey;
		logic nextKey;
	} fpil_keys_t;

	typedef struct packed {
		logic alarm;
		logic fault;
		logic isolate;
		logic mains;
		logic chargerBattery;
		logic sysFault;
		logic bellIso;
		logic warnIso;
	} fpil_lamps_t;

endpackage : fpil_pkg

// file: fpil_top.sv
// fpil_top: system status lamps, fault sounder and text selection of a fire indicator panel.
// assumes zone and condition inputs synchronous to clk, keys as one-cycle pulses,
// and an AHB-Lite master issuing single whole-word transfers.
//
// How it works
// (R1) five lamp states: off, steady, slow 2 s, normal 0.5 s, rapid 10 Hz
// (R2) alarm lamp steady whenever any zone is in alarm and no alarm is unacknowledged
// (R3) alarm lamp normal flash for unacknowledged listed or unlisted master alarms
// (R4) fault lamp steady on any zone fault; fault count non-zero
// (R5) isolate lamp steady for isolated zones at or below maximum zone
// (R6) isolate lamp normal flash while analogue points are isolated
// (R7) mains lamp steady with mains present, unlit otherwise
// (R8) charger lamp steady on charger malfunction; mains failure alone ignored
// (R9) charger lamp normal flash on low, disconnected battery or failed test
// (R10) pass clears lamp; failed-test indication lapses within one minute
// (R11) charger lamp rapid flash while manual battery test runs
// (R12) system fault lamp steady on a system-level fault
// (R13) system fault lamp slow flash during responder database download
// (R14) bell lamp: off enabled, steady local isolate, slow for networked isolate
// (R15) warning lamp: off, steady local isolate, slow for remote silence
// (R16) warning lamp normal flash on local external silence switch
// (R17) any unmuted fault sounds the fault sounder steadily
// (R18) clear or ack silences sounder and clears fault action text
// (R19) silenced fault still present after 8 hours restarts sounder
// (R20) each new fault after silencing sounds the sounder again
// (R21) next key during alarm steps alarm list, silences internal sounder
// (R22) fault present at base display selects fault action text
// (R23) all flash rates and timeouts from one shared timebase
`timescale 1ns/1ps
module fpil_top #(
	parameter int NZONES = 32,
	parameter int TICK_CYC = fpil_pkg::TICK_CYCLES,
	parameter int RESTART_TK = fpil_pkg::RESTART_TICKS,
	parameter int FAILHOLD_TK = fpil_pkg::FAILHOLD_TICKS
) (
	input wire logic clk,
	input wire logic rst_n,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// panel side
	input wire logic [NZONES-1:0] zoneAlarm,
	input wire logic [NZONES-1:0] zoneFault,
	input wire logic [NZONES-1:0] zoneIsolated,
	input wire fpil_pkg::fpil_cond_t cond,
	input wire fpil_pkg::fpil_keys_t keys,
	output fpil_pkg::fpil_lamps_t lamps,
	output logic faultSounder,
	output logic faultTextShow,
	output logic nextAlarmStep,
	output logic internalSounderSilence
);
	import fpil_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic lampLevel(input fpil_lamp_t st, input logic slowPh, input logic normPh,
		input logic rapidPh);
		case (st)
			LAMP_ON: lampLevel = 1'b1;
			LAMP_SLOW: lampLevel = slowPh;
			LAMP_NORM: lampLevel = normPh;
			LAMP_RAPID: lampLevel = rapidPh;
			default: lampLevel = 1'b0;
		endcase
	endfunction : lampLevel

	function automatic logic [7:0] countOnes(input logic [NZONES-1:0] v);
		logic [7:0] n;
		n = 8'h00;
		for (int i = 0; i < NZONES; i++) begin
			n = n + {7'h00, v[i]};
		end
		countOnes = n;
	endfunction : countOnes

	// ------------------------------------------------------------
	// shared timebase
	// ------------------------------------------------------------
	logic [31:0] divCnt_reg;
	logic tick_reg;
	logic [4:0] tickIdx_reg;
	logic rapidPh_reg;
	logic normPh_reg;
	logic slowPh_reg;

	// (R23) one divider
	// every flash and timeout is counted in the same ticks, so all lamps blink in phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			divCnt_reg <= 32'h0000_0000;
			tick_reg <= 1'b0;
		end else if (divCnt_reg == 32'(TICK_CYC - 1)) begin
			divCnt_reg <= 32'h0000_0000;
			tick_reg <= 1'b1;
		end else begin
			divCnt_reg <= divCnt_reg + 32'h0000_0001;
			tick_reg <= 1'b0;
		end
	end

	// (R1) flash phases
	// tick index runs over one slow half period; faster phases divide it evenly
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tickIdx_reg <= 5'h00;
			rapidPh_reg <= 1'b0;
			normPh_reg <= 1'b0;
			slowPh_reg <= 1'b0;
		end else if (tick_reg) begin
			tickIdx_reg <= (tickIdx_reg == 5'(SLOW_HALF_TICKS - 1)) ? 5'h00 : tickIdx_reg + 5'h01;
			if ((tickIdx_reg % 5'(RAPID_HALF_TICKS)) == 5'(RAPID_HALF_TICKS - 1))
				rapidPh_reg <= ~rapidPh_reg;
			if ((tickIdx_reg % 5'(NORM_HALF_TICKS)) == 5'(NORM_HALF_TICKS - 1))
				normPh_reg <= ~normPh_reg;
			if (tickIdx_reg == 5'(SLOW_HALF_TICKS - 1))
				slowPh_reg <= ~slowPh_reg;
		end
	end

	// ------------------------------------------------------------
	// register bus
	// ------------------------------------------------------------
	logic [31:0] ctrl_reg;
	logic wrPend_reg;
	logic [7:0] wrAddr_reg;
	logic [7:0] faultCnt_reg;
	logic [31:0] statusWord;
	logic addrPhase;

	assign addrPhase = hsel & htrans[1] & hready;

	// zero wait state slave, always OKAY
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// write address latched in address phase, data taken in data phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPend_reg <= 1'b0;
			wrAddr_reg <= 8'h00;
			ctrl_reg <= CTRL_RESET;
		end else begin
			wrPend_reg <= addrPhase & hwrite;
			wrAddr_reg <= haddr[7:0];
			if (wrPend_reg && wrAddr_reg == ADDR_CTRL)
				ctrl_reg <= hwdata;
		end
	end

	// read data registered at the address phase; unmapped reads give zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			case (haddr[7:0])
				ADDR_CTRL: hrdata <= ctrl_reg;
				ADDR_STATUS: hrdata <= statusWord;
				ADDR_FAULTCNT: hrdata <= {24'h000000, faultCnt_reg};
				ADDR_ZONEFLT: hrdata <= 32'(zoneFault);
				default: hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// lamp state decisions
	// ------------------------------------------------------------
	logic [NZONES-1:0] isoMask;
	logic failHold_reg;
	logic [15:0] failCnt_reg;
	fpil_lamp_t stAlarm, stFault, stIso, stMains, stChg, stSys, stBell, stWarn;

	// (R5) only zones numbered up to the maximum zone count toward isolate
	always_comb begin
		for (int i = 0; i < NZONES; i++) begin
			isoMask[i] = (i + 1) <= int'(ctrl_reg[CTRL_MAXZONE_LSB +: 8]);
		end
	end

	// (R10) failed-test hold
	// pass clears it at once, otherwise it lapses after one minute of ticks
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			failHold_reg <= 1'b0;
			failCnt_reg <= 16'h0000;
		end else if (cond.batteryTestDone) begin
			failHold_reg <= ~cond.batteryTestPass;
			failCnt_reg <= 16'h0000;
		end else if (failHold_reg && tick_reg) begin
			failCnt_reg <= failCnt_reg + 16'h0001;
			if (failCnt_reg == 16'(FAILHOLD_TK - 1))
				failHold_reg <= 1'b0;
		end
	end

	always_comb begin
		// (R2) (R3) any alarm steady, unacknowledged alarm flashes
		if (cond.unackListAlarm || cond.unackMasterUnlisted)
			stAlarm = LAMP_NORM;
		else if (|zoneAlarm)
			stAlarm = LAMP_ON;
		else
			stAlarm = LAMP_OFF;
		// (R4) zone fault regardless of isolation
		stFault = (|zoneFault) ? LAMP_ON : LAMP_OFF;
		// (R5) (R6) zone isolate steady takes precedence over point flash
		if (|(zoneIsolated & isoMask))
			stIso = LAMP_ON;
		else if (cond.pointIsolated)
			stIso = LAMP_NORM;
		else
			stIso = LAMP_OFF;
		// (R7) mains present
		stMains = cond.mainsPresent ? LAMP_ON : LAMP_OFF;
		// (R8) (R9) (R11) running test first; mains state never enters
		if (cond.batteryTestRunning)
			stChg = LAMP_RAPID;
		else if (failHold_reg || cond.batteryLow || cond.batteryDisconnected)
			stChg = LAMP_NORM;
		else if (cond.chargerFault)
			stChg = LAMP_ON;
		else
			stChg = LAMP_OFF;
		// (R12) (R13) a real fault outranks download progress
		if (cond.systemFault)
			stSys = LAMP_ON;
		else if (cond.dbDownload)
			stSys = LAMP_SLOW;
		else
			stSys = LAMP_OFF;
		// (R14) networked isolate only when feature enabled
		if (cond.bellLocalIso)
			stBell = LAMP_ON;
		else if (cond.bellNetIso && ctrl_reg[CTRL_BELLNET_BIT])
			stBell = LAMP_SLOW;
		else
			stBell = LAMP_OFF;
		// (R15) (R16) local isolate, then local switch, then remote silence
		if (cond.warnLocalIso)
			stWarn = LAMP_ON;
		else if (cond.warnLocalExtSilence)
			stWarn = LAMP_NORM;
		else if (cond.warnRemoteSilence)
			stWarn = LAMP_SLOW;
		else
			stWarn = LAMP_OFF;
	end

	// (R1) lamp drive from states and shared phases
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lamps <= '0;
		end else begin
			lamps.alarm <= lampLevel(stAlarm, slowPh_reg, normPh_reg, rapidPh_reg);
			lamps.fault <= lampLevel(stFault, slowPh_reg, normPh_reg, rapidPh_reg);
			lamps.isolate <= lampLevel(stIso, slowPh_reg, normPh_reg, rapidPh_reg);
			lamps.mains <= lampLevel(stMains, slowPh_reg, normPh_reg, rapidPh_reg);
			lamps.chargerBattery <= lampLevel(stChg, slowPh_reg, normPh_reg, rapidPh_reg);
			lamps.sysFault <= lampLevel(stSys, slowPh_reg, normPh_reg, rapidPh_reg);
			lamps.bellIso <= lampLevel(stBell, slowPh_reg, normPh_reg, rapidPh_reg);
			lamps.warnIso <= lampLevel(stWarn, slowPh_reg, normPh_reg, rapidPh_reg);
		end
	end

	// (R4) fault total for the base display
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			faultCnt_reg <= 8'h00;
		else
			faultCnt_reg <= countOnes(zoneFault);
	end

	assign statusWord = {faultCnt_reg, 5'h00, stAlarm, 1'b0, stChg, 3'h0, faultSounder, lamps};

	// ------------------------------------------------------------
	// fault sounder
	// ------------------------------------------------------------
	logic [NZONES-1:0] zoneFaultPrev_reg;
	logic [3:0] srcPrev_reg;
	logic [3:0] srcNow;
	logic [3:0] srcMute;
	logic newFault;
	logic anyFault;
	logic silenceKey;
	fpil_snd_t snd_reg;
	logic [31:0] silCnt_reg;

	assign srcMute = ctrl_reg[CTRL_MUTE_LSB +: 4];
	assign srcNow[MUTE_ZONE] = |zoneFault;
	assign srcNow[MUTE_SYS] = cond.systemFault;
	assign srcNow[MUTE_CHG] = cond.chargerFault;
	assign srcNow[MUTE_BAT] = cond.batteryLow | cond.batteryDisconnected | failHold_reg;
	assign anyFault = |(srcNow & ~srcMute);
	assign silenceKey = keys.clearKey | keys.ackKey;

	// (R20) a fresh zone or source fault counts as new, even while another persists
	assign newFault = (|(zoneFault & ~zoneFaultPrev_reg) & ~srcMute[MUTE_ZONE])
		| (|(srcNow & ~srcPrev_reg & ~srcMute));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			zoneFaultPrev_reg <= '0;
			srcPrev_reg <= 4'h0;
		end else begin
			zoneFaultPrev_reg <= zoneFault;
			srcPrev_reg <= srcNow;
		end
	end

	// (R17) (R18) (R19) (R20) sounder sequence
	// a new fault in the same cycle as a silence key wins, so no fault goes unannounced
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			snd_reg <= SND_QUIET;
			silCnt_reg <= 32'h0000_0000;
		end else begin
			case (snd_reg)
				SND_QUIET: begin
					if (anyFault)
						snd_reg <= SND_SOUNDING;
				end
				SND_SOUNDING: begin
					silCnt_reg <= 32'h0000_0000;
					if (!anyFault)
						snd_reg <= SND_QUIET;
					else if (silenceKey && !newFault)
						snd_reg <= SND_SILENCED;
				end
				SND_SILENCED: begin
					if (!anyFault) begin
						snd_reg <= SND_QUIET;
					end else if (newFault) begin
						snd_reg <= SND_SOUNDING;
					end else if (tick_reg) begin
						silCnt_reg <= silCnt_reg + 32'h0000_0001;
						if (silCnt_reg == 32'(RESTART_TK - 1))
							snd_reg <= SND_SOUNDING;
					end
				end
				default: snd_reg <= SND_QUIET;
			endcase
		end
	end

	// steady tone, no pulsing
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			faultSounder <= 1'b0;
		else
			faultSounder <= (snd_reg == SND_SOUNDING);
	end

	// (R22) (R18) fault text at base display until silenced
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			faultTextShow <= 1'b0;
		else
			faultTextShow <= anyFault & cond.atBaseDisplay & (snd_reg != SND_SILENCED);
	end

	// (R21) next key while an alarm stands
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nextAlarmStep <= 1'b0;
			internalSounderSilence <= 1'b0;
		end else begin
			nextAlarmStep <= keys.nextKey & (|zoneAlarm);
			internalSounderSilence <= keys.nextKey & (|zoneAlarm);
		end
	end

endmodule : fpil_top

// file: fpil_top_assertions.sv
// fpil_top_assertions: temporal checks on the panel side of the indicator block.
// assumes it is bound into fpil_top and sees only that module's ports.
`timescale 1ns/1ps
module fpil_checker #(
	parameter int NZONES = 32,
	parameter int TICK_CYC = fpil_pkg::TICK_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [NZONES-1:0] zoneAlarm,
	input wire logic [NZONES-1:0] zoneFault,
	input wire fpil_pkg::fpil_cond_t cond,
	input wire fpil_pkg::fpil_keys_t keys,
	input wire fpil_pkg::fpil_lamps_t lamps,
	input wire logic faultSounder,
	input wire logic nextAlarmStep,
	input wire logic internalSounderSilence
);
	import fpil_pkg::*;
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// one domain; $past(rst_n) skips the edge just after release
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	chk_mains_lamp: assert property ($past(rst_n) |-> lamps.mains == $past(cond.mainsPresent))
		else $error("mains lamp does not follow supply");
	chk_fault_lamp: assert property ($past(rst_n) |-> lamps.fault == $past(|zoneFault))
		else $error("fault lamp does not follow zone faults");
	chk_alarm_steady: assert property ($past(rst_n) && $past(|zoneAlarm)
		&& !$past(cond.unackListAlarm || cond.unackMasterUnlisted) |-> lamps.alarm)
		else $error("alarm lamp not steady with zone alarm");
	chk_alarm_idle: assert property ($past(rst_n)
		&& !$past((|zoneAlarm) || cond.unackListAlarm || cond.unackMasterUnlisted) |-> !lamps.alarm)
		else $error("alarm lamp lit without cause");
	chk_next_step: assert property ($past(rst_n) |->
		{nextAlarmStep, internalSounderSilence} == {2{$past(keys.nextKey && (|zoneAlarm))}})
		else $error("next key pulses wrong");
	chk_key_silence: assert property (faultSounder && (keys.clearKey || keys.ackKey)
		&& $stable(zoneFault) && $stable(cond) |=> ##1 !faultSounder)
		else $error("sounder not silenced by key");
	chk_sysfault_lamp: assert property ($past(rst_n) && $past(cond.systemFault) |-> lamps.sysFault)
		else $error("system fault lamp not steady");
	// lit run while a test runs; a rapid half period is one tick, so a longer run means no blink
	int litRun;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			litRun <= 0;
		else
			litRun <= (cond.batteryTestRunning && lamps.chargerBattery) ? litRun + 1 : 0;
	end
	chk_rapid_blink: assert property (litRun <= TICK_CYC)
		else $error("charger lamp not blinking rapidly");
	cov_silence: cover property (faultSounder && keys.ackKey);
	cov_next: cover property (nextAlarmStep);
	cov_test: cover property (cond.batteryTestRunning && lamps.chargerBattery);
endmodule : fpil_checker

bind fpil_top fpil_checker #(.NZONES(NZONES), .TICK_CYC(TICK_CYC)) u_chk (.clk(clk), .rst_n(rst_n),
	.zoneAlarm(zoneAlarm),
	.zoneFault(zoneFault), .cond(cond), .keys(keys), .lamps(lamps), .faultSounder(faultSounder),
	.nextAlarmStep(nextAlarmStep), .internalSounderSilence(internalSounderSilence));

// file: fpil_panel_model.sv
// fpil_panel_model: operator keypad and battery test gear facing the indicator block.
// assumes press and testStart are bench levels sampled on clk.
`timescale 1ns/1ps
module fpil_panel_model #(
	parameter int RUN_CYC = 200
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] press,
	input wire logic testStart,
	input wire logic testOk,
	output fpil_pkg::fpil_keys_t keys,
	output logic testRun,
	output logic testDone,
	output logic testPass
);
	import fpil_pkg::*;
	logic [2:0] pressReg;
	int runCnt;
	// ------------------------------------------------------------
	// keypad and tester
	// ------------------------------------------------------------
	// one pulse per press, a held key never repeats
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pressReg <= 3'h0;
			keys <= '0;
		end else begin
			pressReg <= press;
			keys <= fpil_keys_t'(press & ~pressReg);
		end
	end
	// fixed-length test, verdict with the done pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			runCnt <= 0;
			testDone <= 1'b0;
		end else begin
			testDone <= (runCnt == 1);
			if (testStart && runCnt == 0) begin
				runCnt <= RUN_CYC;
			end else if (runCnt != 0) begin
				runCnt <= runCnt - 1;
			end
		end
	end
	// verdict is meaningless off the pulse, so show the opposite there
	assign testRun = (runCnt != 0);
	assign testPass = testDone ? testOk : !testOk;
endmodule : fpil_panel_model

// file: fire_panel_indicator_logic_tb.sv
// fire_panel_indicator_logic_tb: self-checking bench for the indicator block.
// assumes fpil_pkg, fpil_top, the panel model and the bound checker are compiled.
`timescale 1ns/1ps
module fire_panel_indicator_logic_tb;
	import fpil_pkg::*;
	localparam logic [17:0] BASE = 18'h20000;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, faultSounder, faultTextShow, nextAlarmStep, intSil;
	logic [31:0] hrdata;
	logic [7:0] zoneAlarm = 8'h0;
	logic [7:0] zoneFault = 8'h0;
	logic [7:0] zoneIsolated = 8'h0;
	logic [2:0] press = 3'h0;
	logic testStart = 1'b0;
	logic testOk = 1'b0;
	logic testRun, testDone, testPass;
	logic [31:0] rnd = 32'h0b7e;
	fpil_cond_t condV = BASE;
	fpil_cond_t condIn;
	fpil_keys_t keys;
	fpil_lamps_t lampsV;
	int errTotal = 0;
	int nTests = 0;
	int nSteps = 0;

	fpil_top #(.NZONES(8), .TICK_CYC(4), .RESTART_TK(10), .FAILHOLD_TK(60)) dut (.clk(clk), .rst_n(rst_n),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .zoneAlarm(zoneAlarm),
		.zoneFault(zoneFault), .zoneIsolated(zoneIsolated), .cond(condIn), .keys(keys), .lamps(lampsV),
		.faultSounder(faultSounder), .faultTextShow(faultTextShow), .nextAlarmStep(nextAlarmStep),
		.internalSounderSilence(intSil));
	fpil_panel_model #(.RUN_CYC(200)) u_panel (.clk(clk), .rst_n(rst_n), .press(press), .testStart(testStart),
		.testOk(testOk), .keys(keys), .testRun(testRun), .testDone(testDone), .testPass(testPass));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// tester drives the battery test fields
	always_comb begin
		condIn = condV;
		condIn.batteryTestRunning = testRun;
		condIn.batteryTestDone = testDone;
		condIn.batteryTestPass = testPass;
	end
	initial begin
		forever #2 clk = ~clk;
	end
	// next-key pulses seen on both outputs together
	always @(posedge clk) begin
		if (nextAlarmStep && intSil)
			nSteps++;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] ones(input logic [7:0] v);
		ones = 32'h0;
		for (int i = 0; i < 8; i++) ones = ones + 32'(v[i]);
	endfunction : ones
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			errTotal++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic stopTest;
		$display("comparisons %0d mismatches %0d", nTests, errTotal);
		if (errTotal == 0 && nTests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stopTest
	// bounded wait for hready, a hang ends the run
	task automatic ready;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			errTotal++;
			stopTest();
		end
	endtask : ready
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		ready();
		r = hrdata;
		check(32'(hresp), 32'h0);
	endtask : bus
	task automatic key(input logic [2:0] k);
		press <= k;
		@(posedge clk);
		press <= 3'h0;
		repeat (4) @(posedge clk);
	endtask : key
	// toggles over 160 clocks tell the five lamp states apart
	task automatic lampMode(input int idx, output logic [31:0] m);
		logic first, prev;
		int t;
		first = lampsV[idx];
		prev = first;
		t = 0;
		repeat (160) begin
			@(posedge clk);
			if (lampsV[idx] !== prev) t++;
			prev = lampsV[idx];
		end
		m = (t == 0) ? {31'h0, first} : (t <= 3) ? 32'(LAMP_SLOW) : (t <= 10) ? 32'(LAMP_NORM) : 32'(LAMP_RAPID);
	endtask : lampMode
	// flip one condition bit, or light random zones, and classify a lamp
	task automatic lampCase(input int pos, input int zsel, input int idx, input fpil_lamp_t exp);
		logic [31:0] m;
		rnd = lfsr(rnd);
		condV <= BASE ^ (18'h1 << pos);
		zoneAlarm <= (zsel == 1) ? (rnd[7:0] | 8'h01) : 8'h0;
		zoneFault <= (zsel == 2) ? (rnd[7:0] | 8'h01) : 8'h0;
		zoneIsolated <= (zsel == 3) ? (rnd[7:0] | 8'h01) : 8'h0;
		repeat (8) @(posedge clk);
		lampMode(idx, m);
		check(m, 32'(exp));
	endtask : lampCase

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic [7:0] mask;
		int n;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		bus(1'b0, ADDR_CTRL, 32'h0, r);
		check(r, CTRL_RESET);
		bus(1'b1, ADDR_FAULTCNT, 32'hffff_ffff, r);
		bus(1'b0, ADDR_FAULTCNT, 32'h0, r);
		check(r, 32'h0);
		bus(1'b0, 8'h40, 32'h0, r);
		check(r, 32'h0);
		$display("test registers done");
		rnd = lfsr(rnd);
		mask = rnd[7:0] & 8'h7f | 8'h01;
		zoneFault <= mask;
		condV <= BASE | 18'h1;
		repeat (4) @(posedge clk);
		check(32'(faultSounder), 32'h1);
		check(32'(faultTextShow), 32'h1);
		bus(1'b0, ADDR_FAULTCNT, 32'h0, r);
		check(r, ones(mask));
		bus(1'b0, ADDR_ZONEFLT, 32'h0, r);
		check(r, 32'(mask));
		bus(1'b0, ADDR_STATUS, 32'h0, r);
		check(r & 32'h1ff, 32'h0000_0150);
		key(3'h2);
		check({faultSounder, faultTextShow}, 32'h0);
		zoneFault <= mask | 8'h80;
		repeat (4) @(posedge clk);
		check(32'(faultSounder), 32'h1);
		key(3'h4);
		check(32'(faultSounder), 32'h0);
		n = 0;
		while (faultSounder !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		check(32'(n > 25 && n < 60), 32'h1);
		if (n >= 100) stopTest();
		bus(1'b1, ADDR_CTRL, 32'h0001_00ff, r);
		repeat (4) @(posedge clk);
		check(32'(faultSounder), 32'h0);
		bus(1'b1, ADDR_CTRL, 32'h0000_00ff, r);
		repeat (4) @(posedge clk);
		check(32'(faultSounder), 32'h1);
		zoneFault <= 8'h0;
		zoneIsolated <= 8'h20;
		for (int mz = 5; mz <= 6; mz++) begin
			bus(1'b1, ADDR_CTRL, 32'(mz), r);
			repeat (4) @(posedge clk);
			check(32'(lampsV.isolate), 32'(mz == 6));
		end
		lampCase(7, 0, 1, LAMP_OFF);
		for (int a = 0; a < 2; a++) begin
			zoneAlarm <= a[0] ? (rnd[7:0] | 8'h01) : 8'h0;
			key(3'h1);
		end
		check(32'(nSteps), 32'h1);
		$display("test sounder done");
		bus(1'b1, ADDR_CTRL, 32'h0000_01ff, r);
		lampCase(17, 0, 4, LAMP_OFF);
		lampCase(17, 0, 3, LAMP_OFF);
		lampCase(0, 0, 4, LAMP_ON);
		lampCase(16, 0, 3, LAMP_ON);
		lampCase(15, 0, 3, LAMP_NORM);
		lampCase(14, 0, 3, LAMP_NORM);
		lampCase(10, 0, 2, LAMP_ON);
		lampCase(9, 0, 2, LAMP_SLOW);
		lampCase(8, 0, 1, LAMP_ON);
		lampCase(7, 0, 1, LAMP_SLOW);
		lampCase(6, 0, 0, LAMP_ON);
		lampCase(5, 0, 0, LAMP_SLOW);
		lampCase(4, 0, 0, LAMP_NORM);
		lampCase(3, 0, 7, LAMP_NORM);
		lampCase(2, 0, 7, LAMP_NORM);
		lampCase(0, 1, 7, LAMP_ON);
		lampCase(0, 2, 6, LAMP_ON);
		lampCase(0, 3, 5, LAMP_ON);
		lampCase(1, 0, 5, LAMP_NORM);
		$display("test lamps done");
		condV <= BASE;
		for (int p = 0; p < 2; p++) begin
			testOk <= !p[0];
			testStart <= 1'b1;
			@(posedge clk);
			testStart <= 1'b0;
			repeat (9) @(posedge clk);
			lampMode(3, r);
			check(r, 32'(LAMP_RAPID));
			n = 0;
			while (testDone !== 1'b1 && n < 400) begin
				@(posedge clk);
				n++;
			end
			check(32'(n < 400), 32'h1);
			if (n >= 400) stopTest();
			repeat (4) @(posedge clk);
			lampMode(3, r);
			check(r, p ? 32'(LAMP_NORM) : 32'(LAMP_OFF));
		end
		repeat (90) @(posedge clk);
		lampMode(3, r);
		check(r, 32'(LAMP_OFF));
		$display("test battery done");
		stopTest();
	end
endmodule : fire_panel_indicator_logic_tb
